// ---- gpcfg_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - After reset the block runs on the configuration loaded into the store until rewritten.
// - After the 55 ms window strap pins become ordinary function pins.
// - All clock outputs stay disabled out of reset until the store has loaded.
// - Pin two high enables differential output zero without software.
// - Configuration store holds 253 bytes.
// - Store loads from one-time memory if present, else built-in defaults.
// - Host may rewrite any store byte at run time; it takes effect.
// - Each pin's function comes from its whole function byte: bits 6:0 with bit 7 clear, else only code 0x80.
// - Code 0x00 is a plain input with no function.
// - Codes 0x10..0x1C are external loss-of-signal inputs for references 0..3.
// - Codes 0x20, 0x28 are interval-error clear enables, OR-ed with register bits.
// - Codes 0x44..0x47 and 0x4C..0x4F stop synthesizer 0/1 dividers C, D, OR-ed with register.
// - Codes 0x50..0x5F stop synthesizer 2/3 dividers A..D, OR-ed with register.
// - Codes 0x60..0x66 enable differential outputs 0..3, OR-ed with register.
// - A pin may drive the host interrupt output.
// - Pins 1:0 at start pick master clock: 10 is 20 MHz, 11 is 24.576 MHz.
module gpcfg_top #(
  parameter int STRAP_CYCLES = gpcfg_pkg::STRAP_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [11:0] GPIO_IN,
  output logic [11:0] GPIO_OUT,
  output logic [11:0] GPIO_OE,
  input wire logic OTP_PRESENT,
  input wire logic [7:0] OTP_DATA,
  output logic [7:0] OTP_ADDR,
  output logic [3:0] REF_LOS,
  output logic [1:0] TIE_CLEAR,
  output logic [7:0] STOP_SYN01,
  output logic [15:0] STOP_SYN23,
  output logic [3:0] HPDIFF_EN,
  output logic [1:0] MCLK_SEL,
  output logic MCLK_VALID,
  output logic IRQ
);
  localparam int N = gpcfg_pkg::GPIO_N;

  // Address decode shared by the read and write paths
  function automatic logic [2:0] addr_kind(input logic [11:0] a);
    if (a[1:0] != 2'h0) begin
      return gpcfg_pkg::K_BAD;
    end
    if (a < gpcfg_pkg::ADDR_CFG_END) begin
      return gpcfg_pkg::K_CFG;
    end
    case (a)
      gpcfg_pkg::ADDR_IRQ_STAT: return gpcfg_pkg::K_STAT;
      gpcfg_pkg::ADDR_IRQ_CLR: return gpcfg_pkg::K_CLR;
      gpcfg_pkg::ADDR_IRQ_EN: return gpcfg_pkg::K_EN;
      gpcfg_pkg::ADDR_STRAP: return gpcfg_pkg::K_STRAP;
      default: return gpcfg_pkg::K_BAD;
    endcase
  endfunction : addr_kind

  logic [7:0] cfg_mem [0:gpcfg_pkg::CFG_DEPTH-1];
  gpcfg_pkg::gpcfg_ld_t ld_state_reg;
  logic [7:0] ld_idx_reg;
  logic otp_used_reg;
  logic load_done;
  logic [gpcfg_pkg::WIN_W-1:0] win_cnt_reg;
  logic win_done_reg;
  logic [4:0] strap_reg;
  logic mclk_valid_reg;
  logic awready_reg, wready_reg, aw_hold_reg, w_hold_reg;
  logic [11:0] awaddr_reg, araddr_q;
  logic [7:0] wdata_reg;
  logic wlane_reg;
  logic bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic aw_fire, w_fire, ar_fire, do_write;
  logic [2:0] wr_kind, rd_kind;
  logic wr_cfg, wr_clr, wr_en;
  logic [gpcfg_pkg::IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_evt;
  logic [3:0] los_reg, hpd_reg;
  logic [1:0] tie_reg;
  logic [7:0] stop01_reg;
  logic [15:0] stop23_reg;
  logic [11:0] gpo_reg, gpoe_reg;
  logic irq_reg;
  logic [3:0] d_los [N];
  logic [1:0] d_tie [N];
  logic [7:0] d_st01 [N];
  logic [15:0] d_st23 [N];
  logic [3:0] d_hpd [N];
  logic [N-1:0] d_irq;
  logic [3:0] pin_los, pin_hpd;
  logic [1:0] pin_tie;
  logic [7:0] pin_st01;
  logic [15:0] pin_st23;
  logic [N-1:0] pin_irq;
  logic [31:0] rd_word;

  assign load_done = (ld_state_reg == gpcfg_pkg::LD_DONE);

  // Loader walks the whole store once; the one-time memory answers in the same cycle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ld_state_reg <= gpcfg_pkg::LD_IDLE;
      ld_idx_reg <= 8'h00;
      otp_used_reg <= 1'b0;
    end else begin
      case (ld_state_reg)
        gpcfg_pkg::LD_IDLE: begin
          otp_used_reg <= OTP_PRESENT;
          ld_state_reg <= gpcfg_pkg::LD_RUN;
        end
        gpcfg_pkg::LD_RUN: begin
          if (ld_idx_reg == gpcfg_pkg::CFG_LAST) begin
            ld_state_reg <= gpcfg_pkg::LD_DONE;
          end else begin
            ld_idx_reg <= ld_idx_reg + 8'h01;
          end
        end
        gpcfg_pkg::LD_DONE: begin
          ld_state_reg <= gpcfg_pkg::LD_DONE;
        end
        default: begin
          ld_state_reg <= gpcfg_pkg::LD_IDLE;
        end
      endcase
    end
  end

  // Store has no reset: the loader fills every byte before pins or writes use it; bus reads are not held off
  always_ff @(posedge CLK_SYS) begin
    if (ld_state_reg == gpcfg_pkg::LD_RUN) begin
      cfg_mem[ld_idx_reg] <= otp_used_reg ? OTP_DATA : gpcfg_pkg::CFG_DEFAULT;
    end else if (wr_cfg) begin
      cfg_mem[awaddr_reg[9:2]] <= wdata_reg;
    end
  end

  // Strap window from reset release; straps follow the pins until it closes
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      win_cnt_reg <= '0;
      win_done_reg <= 1'b0;
      strap_reg <= 5'h00;
      mclk_valid_reg <= 1'b0;
    end else if (!win_done_reg) begin
      strap_reg <= {GPIO_IN[5], GPIO_IN[4], GPIO_IN[3], GPIO_IN[1], GPIO_IN[0]};
      if (win_cnt_reg == gpcfg_pkg::WIN_W'(STRAP_CYCLES - 1)) begin
        win_done_reg <= 1'b1;
        mclk_valid_reg <= GPIO_IN[1]; // Same sample as the last strap capture
      end else begin
        win_cnt_reg <= win_cnt_reg + gpcfg_pkg::WIN_W'(1);
      end
    end
  end

  // One decoder per pin, fed by its function byte
  for (genvar g = 0; g < N; g++) begin : g_pin
    gpcfg_func_dec u_dec (
      .code(cfg_mem[gpcfg_pkg::IDX_GPIO0 + 8'(g)]),
      .loss_of_signal(d_los[g]),
      .time_interval_error(d_tie[g]),
      .stop01(d_st01[g]),
      .stop23(d_st23[g]),
      .hpd(d_hpd[g]),
      .irq_drv(d_irq[g])
    );
  end

  // Pin function bytes act only once straps are released and the store is valid
  always_comb begin
    pin_los = '0;
    pin_tie = '0;
    pin_st01 = '0;
    pin_st23 = '0;
    pin_hpd = '0;
    pin_irq = '0;
    for (int i = 0; i < N; i++) begin
      pin_irq[i] = d_irq[i] && win_done_reg && load_done;
      if (GPIO_IN[i] && win_done_reg && load_done) begin
        pin_los = pin_los | d_los[i];
        pin_tie = pin_tie | d_tie[i];
        pin_st01 = pin_st01 | d_st01[i];
        pin_st23 = pin_st23 | d_st23[i];
        pin_hpd = pin_hpd | d_hpd[i];
      end
    end
  end

  // Control outputs: pin functions OR-ed with their register bits; loss-of-signal has none
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      los_reg <= 4'h0;
      tie_reg <= 2'h0;
      stop01_reg <= 8'h00;
      stop23_reg <= 16'h0000;
      hpd_reg <= 4'h0;
    end else if (!load_done) begin
      hpd_reg <= 4'h0;
    end else begin
      los_reg <= pin_los;
      tie_reg <= pin_tie | cfg_mem[gpcfg_pkg::IDX_TIE][1:0];
      stop01_reg <= pin_st01 | cfg_mem[gpcfg_pkg::IDX_STOP01];
      stop23_reg <= pin_st23 | {cfg_mem[gpcfg_pkg::IDX_STOP23H], cfg_mem[gpcfg_pkg::IDX_STOP23L]};
      hpd_reg <= pin_hpd | cfg_mem[gpcfg_pkg::IDX_HPD_EN][3:0] | {3'h0, GPIO_IN[2]};
    end
  end

  // Interrupt pin drive; strap pins stay undriven through the window
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      gpo_reg <= 12'h000;
      gpoe_reg <= 12'h000;
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_en_reg);
      gpoe_reg <= pin_irq;
      gpo_reg <= pin_irq & {N{|(irq_stat_reg & irq_en_reg)}};
    end
  end

  // Events: rising loss-of-signal, load complete, strap window closed
  assign irq_evt = {win_done_reg == 1'b0 && win_cnt_reg == gpcfg_pkg::WIN_W'(STRAP_CYCLES - 1),
                    ld_state_reg == gpcfg_pkg::LD_RUN && ld_idx_reg == gpcfg_pkg::CFG_LAST,
                    pin_los & ~los_reg & {4{load_done}}};

  // Sticky status: a new event in the clear cycle survives
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? wdata_reg[gpcfg_pkg::IRQ_W-1:0] : '0)) | irq_evt;
      if (wr_en) begin
        irq_en_reg <= wdata_reg[gpcfg_pkg::IRQ_W-1:0];
      end
    end
  end

  // Write channel: address and data taken in either order, held until both are in
  assign aw_fire = S_AXI_AWVALID && awready_reg;
  assign w_fire = S_AXI_WVALID && wready_reg;
  assign do_write = aw_hold_reg && w_hold_reg;
  assign wr_kind = addr_kind(awaddr_reg);
  assign wr_cfg = do_write && wlane_reg && wr_kind == gpcfg_pkg::K_CFG;
  assign wr_clr = do_write && wlane_reg && wr_kind == gpcfg_pkg::K_CLR;
  assign wr_en = do_write && wlane_reg && wr_kind == gpcfg_pkg::K_EN;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 8'h00;
      wlane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= gpcfg_pkg::RESP_OKAY;
    end else begin
      // Writes wait for the loader so they cannot collide with it
      awready_reg <= load_done && !aw_fire && !aw_hold_reg && !(bvalid_reg && !S_AXI_BREADY);
      wready_reg <= load_done && !w_fire && !w_hold_reg && !(bvalid_reg && !S_AXI_BREADY);
      if (aw_fire) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (w_fire) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA[7:0];
        wlane_reg <= S_AXI_WSTRB[0];
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_kind == gpcfg_pkg::K_BAD) ? gpcfg_pkg::RESP_SLVERR : gpcfg_pkg::RESP_OKAY;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read mux; narrow data sits in the low bits
  assign ar_fire = S_AXI_ARVALID && arready_reg;
  assign araddr_q = S_AXI_ARADDR;
  assign rd_kind = addr_kind(araddr_q);
  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_kind)
      gpcfg_pkg::K_CFG: rd_word[7:0] = cfg_mem[araddr_q[9:2]];
      gpcfg_pkg::K_STAT: rd_word[gpcfg_pkg::IRQ_W-1:0] = irq_stat_reg;
      gpcfg_pkg::K_EN: rd_word[gpcfg_pkg::IRQ_W-1:0] = irq_en_reg;
      gpcfg_pkg::K_STRAP: begin
        rd_word[4:0] = strap_reg;
        rd_word[gpcfg_pkg::ST_WIN_DONE] = win_done_reg;
        rd_word[gpcfg_pkg::ST_LOAD_DONE] = load_done;
        rd_word[gpcfg_pkg::ST_OTP_USED] = otp_used_reg;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= gpcfg_pkg::RESP_OKAY;
    end else begin
      arready_reg <= !ar_fire && !(rvalid_reg && !S_AXI_RREADY);
      if (ar_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= (rd_kind == gpcfg_pkg::K_BAD) ? gpcfg_pkg::RESP_SLVERR : gpcfg_pkg::RESP_OKAY;
      end else if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY = wready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign OTP_ADDR = ld_idx_reg;
  assign REF_LOS = los_reg;
  assign TIE_CLEAR = tie_reg;
  assign STOP_SYN01 = stop01_reg;
  assign STOP_SYN23 = stop23_reg;
  assign HPDIFF_EN = hpd_reg;
  assign MCLK_SEL = strap_reg[1:0];
  assign MCLK_VALID = mclk_valid_reg;
  assign GPIO_OUT = gpo_reg;
  assign GPIO_OE = gpoe_reg;
  assign IRQ = irq_reg;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_wr_both;
    aw_hold_reg && w_hold_reg;
  endsequence
  sequence s_wr_resp;
    S_AXI_BVALID [*1];
  endsequence

  property p_outs_off;
    !load_done |=> HPDIFF_EN == 4'h0 && STOP_SYN01 == 8'h00;
  endproperty
  a_outs_off: assert property (p_outs_off) else $error("outputs enabled before load");
  property p_pin_two;
    load_done && GPIO_IN[2] |=> HPDIFF_EN[0];
  endproperty
  a_pin_two: assert property (p_pin_two) else $error("pin two did not enable output zero");
  property p_strap_frozen;
    win_done_reg |=> $stable(strap_reg) && MCLK_SEL == $past(strap_reg[1:0]);
  endproperty
  a_strap_frozen: assert property (p_strap_frozen) else $error("strap moved after window");
  property p_no_drive_window;
    !win_done_reg |=> GPIO_OE == 12'h000;
  endproperty
  a_no_drive_window: assert property (p_no_drive_window) else $error("pin driven in strap window");
  property p_load_end;
    ld_state_reg == gpcfg_pkg::LD_RUN && ld_idx_reg == gpcfg_pkg::CFG_LAST |=> load_done ##1 irq_stat_reg[gpcfg_pkg::IRQ_LOAD];
  endproperty
  a_load_end: assert property (p_load_end) else $error("load did not finish");
  property p_write_apply;
    logic [7:0] d;
    logic [7:0] k;
    (wr_cfg, d = wdata_reg, k = awaddr_reg[9:2]) |=> cfg_mem[k] == d;
  endproperty
  a_write_apply: assert property (p_write_apply) else $error("store byte not written");
  property p_wr_resp;
    s_wr_both |=> s_wr_resp;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_tie_or;
    load_done && cfg_mem[gpcfg_pkg::IDX_TIE][0] |=> TIE_CLEAR[0];
  endproperty
  a_tie_or: assert property (p_tie_or) else $error("clear bit not OR-ed");
  property p_los_pin;
    load_done && pin_los[0] |=> REF_LOS[0] && (irq_stat_reg[0] || $past(REF_LOS[0]));
  endproperty
  a_los_pin: assert property (p_los_pin) else $error("loss input not passed");
  property p_irq_level;
    (irq_stat_reg & irq_en_reg) != '0 |=> IRQ;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
endmodule : gpcfg_top
`default_nettype wire

// ---- gpcfg_pkg.sv ----
package gpcfg_pkg;
  // Configuration store geometry
  localparam int CFG_DEPTH = 253;
  localparam logic [7:0] CFG_LAST = 8'h00FC;
  localparam logic [7:0] CFG_DEFAULT = 8'h0000;
  localparam int GPIO_N = 12;
  // Store indices of control bytes and pin function bytes
  localparam logic [7:0] IDX_HPD_EN = 8'h00D0;
  localparam logic [7:0] IDX_TIE = 8'h00D1;
  localparam logic [7:0] IDX_STOP01 = 8'h00D2;
  localparam logic [7:0] IDX_STOP23L = 8'h00D3;
  localparam logic [7:0] IDX_STOP23H = 8'h00D4;
  localparam logic [7:0] IDX_GPIO0 = 8'h00E0;
  // Bus byte addresses
  localparam logic [11:0] ADDR_CFG_END = 12'h03F4;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h0400;
  localparam logic [11:0] ADDR_IRQ_CLR = 12'h0404;
  localparam logic [11:0] ADDR_IRQ_EN = 12'h0408;
  localparam logic [11:0] ADDR_STRAP = 12'h040C;
  // Address kinds
  localparam logic [2:0] K_CFG = 3'h0;
  localparam logic [2:0] K_STAT = 3'h1;
  localparam logic [2:0] K_CLR = 3'h2;
  localparam logic [2:0] K_EN = 3'h3;
  localparam logic [2:0] K_STRAP = 3'h4;
  localparam logic [2:0] K_BAD = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Pin function codes
  localparam logic [6:0] FC_LOS0 = 7'h10;
  localparam logic [6:0] FC_TIE0 = 7'h20;
  localparam logic [6:0] FC_TIE1 = 7'h28;
  localparam logic [6:0] FC_STOP_S0 = 7'h44;
  localparam logic [6:0] FC_STOP_S1 = 7'h4C;
  localparam logic [6:0] FC_STOP_S2 = 7'h50;
  localparam logic [6:0] FC_HPD0 = 7'h60;
  localparam logic [7:0] FC_IRQ_OUT = 8'h0080;
  // Interrupt status layout
  localparam int IRQ_W = 6;
  localparam int IRQ_LOAD = 4;
  localparam int IRQ_STRAP = 5;
  // Strap status word layout
  localparam int ST_WIN_DONE = 8;
  localparam int ST_LOAD_DONE = 9;
  localparam int ST_OTP_USED = 10;
  // Strap window timing
  localparam int STRAP_MS = 55;
  localparam int CLK_KHZ = 100000;
  localparam int STRAP_CYCLES = STRAP_MS * CLK_KHZ;
  localparam int WIN_W = 23;
  // Loader states
  typedef enum logic [2:0] {
    LD_IDLE = 3'b001,
    LD_RUN = 3'b010,
    LD_DONE = 3'b100
  } gpcfg_ld_t;
endpackage : gpcfg_pkg

// ---- gpcfg_func_dec.sv ----
`timescale 1ns/1ns
`default_nettype none
module gpcfg_func_dec (
  input wire logic [7:0] code,
  output logic [3:0] loss_of_signal,
  output logic [1:0] time_interval_error,
  output logic [7:0] stop01,
  output logic [15:0] stop23,
  output logic [3:0] hpd,
  output logic irq_drv
);
  logic [6:0] lo;
  assign lo = code[6:0];

  // Control codes only when the status-select bit is clear; others decode to nothing but 0x80, the interrupt drive
  always_comb begin
    loss_of_signal = '0;
    time_interval_error = '0;
    stop01 = '0;
    stop23 = '0;
    hpd = '0;
    irq_drv = (code == gpcfg_pkg::FC_IRQ_OUT);
    if (!code[7]) begin
      if (lo[6:4] == gpcfg_pkg::FC_LOS0[6:4] && lo[1:0] == 2'h0) begin
        loss_of_signal[lo[3:2]] = 1'b1;
      end
      if (lo == gpcfg_pkg::FC_TIE0) begin
        time_interval_error[0] = 1'b1;
      end
      if (lo == gpcfg_pkg::FC_TIE1) begin
        time_interval_error[1] = 1'b1;
      end
      if (lo[6:2] == gpcfg_pkg::FC_STOP_S0[6:2]) begin
        stop01[{1'b0, lo[1:0]}] = 1'b1;
      end
      if (lo[6:2] == gpcfg_pkg::FC_STOP_S1[6:2]) begin
        stop01[{1'b1, lo[1:0]}] = 1'b1;
      end
      if (lo[6:4] == gpcfg_pkg::FC_STOP_S2[6:4]) begin
        stop23[lo[3:0]] = 1'b1;
      end
      if (lo[6:3] == gpcfg_pkg::FC_HPD0[6:3] && !lo[0]) begin
        hpd[lo[2:1]] = 1'b1;
      end
    end
  end
  // Code zero and unlisted codes fall through with everything low
endmodule : gpcfg_func_dec
`default_nettype wire

// ---- gpcfg_otp_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module gpcfg_otp_model (
  input wire logic [7:0] addr,
  output logic [7:0] data
);
  // Custom image: index folded with a fixed pattern, so a skipped or shifted load shows up
  // Past the last byte the data changes with the address instead of repeating a stale value
  assign data = (addr < 8'h00FD) ? (addr ^ 8'h005A) : ~addr;
endmodule : gpcfg_otp_model
`default_nettype wire

// ---- tb_gpio_control_map_and_strap_config.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin num_errors++; \
  $display("FAIL %s exp %0h got %0h", nm, ex, gt); end end
module tb_gpio_control_map_and_strap_config;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h0000, araddr = 12'h0000, gpio_in = 12'h0002;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, otp_present = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, mclk_valid, irq;
  logic [1:0] bresp, rresp, tie_clear, mclk_sel;
  logic [31:0] rdata;
  logic [11:0] gpio_out, gpio_oe;
  logic [7:0] otp_data, otp_addr, stop01;
  logic [3:0] ref_los, hpd;
  logic [15:0] stop23;
  int num_errors = 0;
  int check_count = 0;
  wire logic [33:0] ctl = {ref_los, tie_clear, stop01, stop23, hpd};
  // Codes on pin 0 and the bit of ctl each should raise; 99 means no control at all
  logic [7:0] fcode [16] = '{8'h00, 8'h30, 8'h48, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h28, 8'h44, 8'h47,
    8'h4F, 8'h50, 8'h5F, 8'h60, 8'h66};
  int fbit [16] = '{99, 99, 99, 30, 31, 32, 33, 28, 29, 20, 23, 27, 4, 19, 0, 3};

  // Short strap window keeps the run small; the real count is far too long to simulate
  gpcfg_top #(.STRAP_CYCLES(20)) DUT (.CLK_SYS(clk_sys), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .OTP_PRESENT(otp_present),
    .OTP_DATA(otp_data), .OTP_ADDR(otp_addr), .REF_LOS(ref_los), .TIE_CLEAR(tie_clear),
    .STOP_SYN01(stop01), .STOP_SYN23(stop23), .HPDIFF_EN(hpd), .MCLK_SEL(mclk_sel),
    .MCLK_VALID(mclk_valid), .IRQ(irq));
  gpcfg_otp_model otp (.addr(otp_addr), .data(otp_data));

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  // Write: address and data offered together, each dropped once taken, then wait for the response
  task automatic axw(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Late response ready makes the slave hold its answer for a cycle
    repeat (2) @(posedge clk_sys);
    bready <= 1'b1;
    do @(posedge clk_sys); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    axw(a, d, r);
    `CHK("bresp", er, r)
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    `CHK("rdata", ed, d)
    `CHK("rresp", er, r)
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // Hang guard, far beyond the under one thousand cycles the tests need
  initial begin
    #200000;
    num_errors++;
    conclude;
  end

  // Main sequence; the first write after each reset also waits out the loader, since writes are held off until it ends
  initial begin
    logic [33:0] ex;
    tick(3);
    rst <= 1'b0;
    tick(2);
    `CHK("outs_off", 34'h0_0000_0000, ctl)
    `CHK("mclk_valid", 1'b0, mclk_valid)
    wr(12'h03F0, 8'hA5, 2'h0);
    rd(12'h03F0, 32'h0000_00A5, 2'h0);
    rd(12'h0040, 32'h0000_0000, 2'h0);
    rd(12'h03F4, 32'h0000_0000, 2'h2);
    rd(12'h0500, 32'h0000_0000, 2'h2);
    rd(12'h040C, 32'h0000_0302, 2'h0);
    `CHK("mclk", 3'h6, {mclk_valid, mclk_sel})
    $display("test startup done");
    gpio_in <= 12'h0001;
    tick(4);
    `CHK("mclk_kept", 2'h2, mclk_sel)
    for (int i = 0; i < 16; i++) begin
      wr(12'h0380, fcode[i], 2'h0);
      gpio_in <= 12'h0001;
      tick(4);
      ex = (fbit[i] < 34) ? (34'h0_0000_0001 << fbit[i]) : 34'h0_0000_0000;
      `CHK("ctl_hi", ex, ctl)
      gpio_in <= 12'h0000;
      tick(4);
      `CHK("ctl_lo", 34'h0_0000_0000, ctl)
    end
    $display("test functions done");
    gpio_in <= 12'h0004;
    tick(4);
    `CHK("pin_two", 4'h1, hpd)
    gpio_in <= 12'h0000;
    wr(12'h0340, 8'h04, 2'h0);
    tick(3);
    `CHK("hpd_reg", 4'h4, hpd)
    wr(12'h0340, 8'h00, 2'h0);
    $display("test enables done");
    rd(12'h0400, 32'h0000_003F, 2'h0);
    wr(12'h0398, 8'h80, 2'h0);
    wr(12'h0408, 8'h01, 2'h0);
    rd(12'h0408, 32'h0000_0001, 2'h0);
    tick(3);
    `CHK("irq_on", 3'h7, {irq, gpio_oe[6], gpio_out[6]})
    wr(12'h0404, 8'h3F, 2'h0);
    tick(3);
    `CHK("irq_clr", 2'h0, {irq, gpio_out[6]})
    rd(12'h0400, 32'h0000_0000, 2'h0);
    wr(12'h0380, 8'h10, 2'h0);
    gpio_in <= 12'h0001;
    tick(4);
    rd(12'h0400, 32'h0000_0001, 2'h0);
    `CHK("irq_los", 1'b1, irq)
    wr(12'h0408, 8'h00, 2'h0);
    tick(3);
    `CHK("irq_mask", 1'b0, irq)
    $display("test interrupt done");
    // Second power-up with a custom image and the other clock strap
    gpio_in <= 12'h0003;
    otp_present <= 1'b1;
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    wr(12'h03F0, 8'h11, 2'h0);
    rd(12'h03F0, 32'h0000_0011, 2'h0);
    rd(12'h0014, 32'h0000_005F, 2'h0);
    rd(12'h040C, 32'h0000_0703, 2'h0);
    `CHK("otp_hpd", 4'hA, hpd)
    // Image bytes at the control indices set some of the register bits OR-ed into the outputs
    `CHK("otp_ctl", 34'h0_3888_E89A, ctl)
    `CHK("mclk_otp", 3'h7, {mclk_valid, mclk_sel})
    $display("test otp done");
    conclude;
  end
endmodule : tb_gpio_control_map_and_strap_config
`default_nettype wire
